// ---- design/cmp_regs_map.vh ----
// Behaviour
// - mode register unused bits read zero, ignored
// - bit 5 enables rising-flag interrupt request
// - bit 4 enables falling-flag interrupt request
// - mode bits 1:0 drive response time
// - control bit 6 shows comparator result
// - rising edge sets bit 5 until cleared
// - falling edge sets bit 4 until cleared
// - control bits 3:2 drive positive hysteresis
// - control bits 1:0 drive negative hysteresis
// - input select register drives analog selectors
// - control bit 7 powers comparator on
// - disabled comparator pin output reads low
// - each edge direction has flag and enable
`ifndef CMP_REGS_MAP_VH
`define CMP_REGS_MAP_VH
`define CMP_B_CTRL_ADDR  8'h9a
`define CMP_A_CTRL_ADDR  8'h9b
`define CMP_B_MODE_ADDR  8'h9c
`define CMP_A_MODE_ADDR  8'h9d
`define CMP_B_SEL_ADDR   8'h9e
`define CMP_A_SEL_ADDR   8'h9f
`define BIT_EN           7
`define BIT_OUT          6
`define BIT_RISE         5
`define BIT_FALL         4
`define MODE_RESET       2'h2
`define CTRL_WMASK       8'hbf
`define MODE_MASK        8'h33
`define SEL_MASK         8'h77
`endif

// ---- design/cmp_regs.v ----
`include "cmp_regs_map.vh"

module cmp_unit #(
  parameter [7:0] CTRL_ADDR = `CMP_A_CTRL_ADDR,
  parameter [7:0] MODE_ADDR = `CMP_A_MODE_ADDR,
  parameter [7:0] SEL_ADDR  = `CMP_A_SEL_ADDR
) (
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire [7:0] addr_i,
  input  wire [7:0] wdata_i,
  input  wire       wr_i,
  input  wire       cmp_raw_i,
  output reg  [7:0] ctrl_ff,
  output reg  [7:0] mode_ff,
  output reg  [7:0] sel_ff,
  output reg        irq_ff,
  output reg        pin_ff
);
  reg       sync1_ff;
  reg       sync2_ff;
  reg       last_ff;
  reg [7:0] nxt_ctrl;
  wire      rise = sync2_ff & ~last_ff;
  wire      fall = ~sync2_ff & last_ff;
  wire      wr_ctrl = wr_i && (addr_i == CTRL_ADDR);

  always @* begin
    nxt_ctrl = ctrl_ff;
    if (wr_ctrl) begin
      nxt_ctrl = wdata_i & `CTRL_WMASK;
    end
    nxt_ctrl[`BIT_OUT] = sync2_ff;
    if (rise) begin
      nxt_ctrl[`BIT_RISE] = 1'b1;
    end
    if (fall) begin
      nxt_ctrl[`BIT_FALL] = 1'b1;
    end
  end

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      last_ff  <= 1'b0;
      ctrl_ff  <= 8'h00;
      mode_ff  <= {6'h00, `MODE_RESET};
      sel_ff   <= 8'h00;
      irq_ff   <= 1'b0;
      pin_ff   <= 1'b0;
    end else begin
      sync1_ff <= cmp_raw_i & ctrl_ff[`BIT_EN];
      sync2_ff <= sync1_ff;
      last_ff  <= sync2_ff;
      ctrl_ff  <= nxt_ctrl;
      if (wr_i && (addr_i == MODE_ADDR)) begin
        mode_ff <= wdata_i & `MODE_MASK;
      end
      if (wr_i && (addr_i == SEL_ADDR)) begin
        sel_ff <= wdata_i & `SEL_MASK;
      end
      irq_ff <= (ctrl_ff[`BIT_RISE] & mode_ff[`BIT_RISE])
              | (ctrl_ff[`BIT_FALL] & mode_ff[`BIT_FALL]);
      pin_ff <= ctrl_ff[`BIT_EN] & sync2_ff;
    end
  end
endmodule // cmp_unit

module cmp_regs (
  input  wire       REF_CLK_I,
  input  wire       SYS_RST_I,
  input  wire [7:0] SFR_ADDR_I,
  input  wire [7:0] SFR_WDATA_I,
  input  wire       SFR_WR_I,
  input  wire       SFR_RD_I,
  input  wire       CMP_A_RAW_I,
  input  wire       CMP_B_RAW_I,
  output reg  [7:0] SFR_RDATA_O,
  output wire       CMP_A_ENABLE_O,
  output wire       CMP_B_ENABLE_O,
  output wire [1:0] CMP_A_RESPONSE_MODE_O,
  output wire [1:0] CMP_B_RESPONSE_MODE_O,
  output wire [1:0] CMP_A_POS_HYST_O,
  output wire [1:0] CMP_B_POS_HYST_O,
  output wire [1:0] CMP_A_NEG_HYST_O,
  output wire [1:0] CMP_B_NEG_HYST_O,
  output wire [2:0] CMP_A_POS_INPUT_SEL_O,
  output wire [2:0] CMP_B_POS_INPUT_SEL_O,
  output wire [2:0] CMP_A_NEG_INPUT_SEL_O,
  output wire [2:0] CMP_B_NEG_INPUT_SEL_O,
  output wire       CMP_A_IRQ_O,
  output wire       CMP_B_IRQ_O,
  output wire       CMP_A_PIN_O,
  output wire       CMP_B_PIN_O
);
  wire [7:0] a_ctrl;
  wire [7:0] a_mode;
  wire [7:0] a_sel;
  wire [7:0] b_ctrl;
  wire [7:0] b_mode;
  wire [7:0] b_sel;

  // one unit per comparator, differing only in addresses
  cmp_unit #(
    .CTRL_ADDR (`CMP_A_CTRL_ADDR),
    .MODE_ADDR (`CMP_A_MODE_ADDR),
    .SEL_ADDR  (`CMP_A_SEL_ADDR)
  ) u_cmp_a (
    .clk_i     (REF_CLK_I),
    .rst_i     (SYS_RST_I),
    .addr_i    (SFR_ADDR_I),
    .wdata_i   (SFR_WDATA_I),
    .wr_i      (SFR_WR_I),
    .cmp_raw_i (CMP_A_RAW_I),
    .ctrl_ff   (a_ctrl),
    .mode_ff   (a_mode),
    .sel_ff    (a_sel),
    .irq_ff    (CMP_A_IRQ_O),
    .pin_ff    (CMP_A_PIN_O)
  );

  cmp_unit #(
    .CTRL_ADDR (`CMP_B_CTRL_ADDR),
    .MODE_ADDR (`CMP_B_MODE_ADDR),
    .SEL_ADDR  (`CMP_B_SEL_ADDR)
  ) u_cmp_b (
    .clk_i     (REF_CLK_I),
    .rst_i     (SYS_RST_I),
    .addr_i    (SFR_ADDR_I),
    .wdata_i   (SFR_WDATA_I),
    .wr_i      (SFR_WR_I),
    .cmp_raw_i (CMP_B_RAW_I),
    .ctrl_ff   (b_ctrl),
    .mode_ff   (b_mode),
    .sel_ff    (b_sel),
    .irq_ff    (CMP_B_IRQ_O),
    .pin_ff    (CMP_B_PIN_O)
  );

  assign CMP_A_ENABLE_O        = a_ctrl[`BIT_EN];
  assign CMP_B_ENABLE_O        = b_ctrl[`BIT_EN];
  assign CMP_A_RESPONSE_MODE_O = a_mode[1:0];
  assign CMP_B_RESPONSE_MODE_O = b_mode[1:0];
  assign CMP_A_POS_HYST_O      = a_ctrl[3:2];
  assign CMP_B_POS_HYST_O      = b_ctrl[3:2];
  assign CMP_A_NEG_HYST_O      = a_ctrl[1:0];
  assign CMP_B_NEG_HYST_O      = b_ctrl[1:0];
  assign CMP_A_POS_INPUT_SEL_O = a_sel[2:0];
  assign CMP_B_POS_INPUT_SEL_O = b_sel[2:0];
  assign CMP_A_NEG_INPUT_SEL_O = a_sel[6:4];
  assign CMP_B_NEG_INPUT_SEL_O = b_sel[6:4];

  // registered read data, valid the edge after SFR_RD_I
  always @(posedge REF_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      SFR_RDATA_O <= 8'h00;
    end else if (SFR_RD_I) begin
      if (SFR_ADDR_I == `CMP_A_CTRL_ADDR) begin
        SFR_RDATA_O <= a_ctrl;
      end else if (SFR_ADDR_I == `CMP_B_CTRL_ADDR) begin
        SFR_RDATA_O <= b_ctrl;
      end else if (SFR_ADDR_I == `CMP_A_MODE_ADDR) begin
        SFR_RDATA_O <= a_mode;
      end else if (SFR_ADDR_I == `CMP_B_MODE_ADDR) begin
        SFR_RDATA_O <= b_mode;
      end else if (SFR_ADDR_I == `CMP_A_SEL_ADDR) begin
        SFR_RDATA_O <= a_sel;
      end else if (SFR_ADDR_I == `CMP_B_SEL_ADDR) begin
        SFR_RDATA_O <= b_sel;
      end else begin
        SFR_RDATA_O <= 8'h00;
      end
    end
  end
endmodule // cmp_regs

// ---- test/cmp_regs_props.sv ----
module cmp_regs_props (
  input wire       REF_CLK_I,
  input wire       SYS_RST_I,
  input wire [7:0] SFR_ADDR_I,
  input wire [7:0] SFR_WDATA_I,
  input wire       SFR_WR_I,
  input wire       SFR_RD_I,
  input wire       CMP_A_RAW_I,
  input wire [7:0] SFR_RDATA_O,
  input wire       CMP_A_ENABLE_O,
  input wire [1:0] CMP_A_RESPONSE_MODE_O,
  input wire [1:0] CMP_A_POS_HYST_O,
  input wire       CMP_A_IRQ_O,
  input wire       CMP_A_PIN_O
);
  default clocking @(posedge REF_CLK_I);
  endclocking
  default disable iff (SYS_RST_I);
  wire wa = SFR_WR_I && SFR_ADDR_I == 8'h9d;
  wire wc = SFR_WR_I && SFR_ADDR_I == 8'h9b;
  wire on = CMP_A_ENABLE_O && CMP_A_RAW_I;
  mode_wr_a: assert property (wa |=>
    CMP_A_RESPONSE_MODE_O == $past(SFR_WDATA_I[1:0])) else $error("mode");
  ctrl_wr_a: assert property (wc |=> {CMP_A_ENABLE_O,
    CMP_A_POS_HYST_O} == {$past(SFR_WDATA_I[7]), $past(SFR_WDATA_I[3:2])})
    else $error("ctrl");
  mode_zero_a: assert property (SFR_RD_I && SFR_ADDR_I == 8'h9d
    |=> (SFR_RDATA_O & 8'hcc) == 8'h00) else $error("mode read");
  pin_off_a: assert property (!CMP_A_ENABLE_O [*4] |->
    !CMP_A_PIN_O) else $error("pin on");
  pin_sync_a: assert property ($rose(CMP_A_RAW_I) && on ##1 on [*3]
    |-> CMP_A_PIN_O) else $error("pin late");
  result_rd_a: assert property (on [*4] ##0 SFR_RD_I &&
    SFR_ADDR_I == 8'h9b |=> SFR_RDATA_O[6]) else $error("result");
  irq_mask_a: assert property (wa && SFR_WDATA_I[5:4] == 2'h0 ##1
    !SFR_WR_I |=> !CMP_A_IRQ_O) else $error("irq mask");
  irq_hold_a: assert property ($fell(CMP_A_IRQ_O) |->
    $past(SFR_WR_I, 2)) else $error("irq drop");
endmodule // cmp_regs_props
bind cmp_regs cmp_regs_props cmp_regs_props_inst (.*);

// ---- test/cmp_analog_model.sv ----
module cmp_analog_model (
  input  wire  clk_i,
  input  wire  en_i,
  input  wire  lvl_i,
  output logic raw_o
);
  // inputs are taken as pins set analog and skipped by routing
  initial raw_o = 1'b0;
  // a powered-down core wanders, so its output toggles
  always @(negedge clk_i) raw_o <= en_i ? lvl_i : ~raw_o;
endmodule // cmp_analog_model

// ---- test/cmp_regs_bench.sv ----
module cmp_regs_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic       REF_CLK_I = 1'b0, SYS_RST_I = 1'b1, la = 1'b0, lb = 1'b0;
  logic       SFR_WR_I = 1'b0, SFR_RD_I = 1'b0;
  logic [7:0] SFR_ADDR_I = 8'h00, SFR_WDATA_I = 8'h00;
  wire        CMP_A_RAW_I, CMP_B_RAW_I, CMP_A_ENABLE_O, CMP_B_ENABLE_O;
  wire        CMP_A_IRQ_O, CMP_B_IRQ_O, CMP_A_PIN_O, CMP_B_PIN_O;
  wire [7:0]  SFR_RDATA_O;
  wire [1:0]  CMP_A_RESPONSE_MODE_O, CMP_B_RESPONSE_MODE_O, CMP_A_POS_HYST_O;
  wire [1:0]  CMP_B_POS_HYST_O, CMP_A_NEG_HYST_O, CMP_B_NEG_HYST_O;
  wire [2:0]  CMP_A_POS_INPUT_SEL_O, CMP_B_POS_INPUT_SEL_O;
  wire [2:0]  CMP_A_NEG_INPUT_SEL_O, CMP_B_NEG_INPUT_SEL_O;
  int         fails = 0, checks_done = 0, cyc = 0;
  cmp_regs cmp_regs_inst (.*);
  cmp_analog_model cmp_analog_model_inst (.clk_i(REF_CLK_I),
    .en_i(CMP_A_ENABLE_O), .lvl_i(la), .raw_o(CMP_A_RAW_I));
  cmp_analog_model cmp_analog_model_inst_b (.clk_i(REF_CLK_I),
    .en_i(CMP_B_ENABLE_O), .lvl_i(lb), .raw_o(CMP_B_RAW_I));
  task chk(input logic [7:0] g, e);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, d);
    @(negedge REF_CLK_I);
    {SFR_ADDR_I, SFR_WDATA_I, SFR_WR_I} = {a, d, 1'b1};
    @(negedge REF_CLK_I);
    SFR_WR_I = 1'b0;
  endtask
  task rd(input logic [7:0] a, e);
    @(negedge REF_CLK_I);
    {SFR_ADDR_I, SFR_RD_I} = {a, 1'b1};
    @(negedge REF_CLK_I);
    SFR_RD_I = 1'b0;
    chk(SFR_RDATA_O, e);
  endtask
  task t_reset;
    rd(8'h9d, 8'h02);
    rd(8'h00, 8'h00);
    chk({CMP_A_RESPONSE_MODE_O, CMP_B_RESPONSE_MODE_O, 4'h0}, 8'ha0);
    $display("reset done");
  endtask
  task t_fields;
    wr(8'h9d, 8'hff);
    rd(8'h9d, 8'h33);
    wr(8'h9f, 8'h9c);
    rd(8'h9f, 8'h14);
    chk({CMP_A_POS_INPUT_SEL_O, CMP_A_NEG_INPUT_SEL_O, 2'h0}, 8'h84);
    wr(8'h9b, 8'hc6);
    rd(8'h9b, 8'h86);
    chk({CMP_A_POS_HYST_O, CMP_A_NEG_HYST_O, 4'h0}, 8'h60);
    $display("fields done");
  endtask
  task t_edge;
    wr(8'h9d, 8'h20);
    la = 1'b1;
    repeat (6) @(negedge REF_CLK_I);
    rd(8'h9b, 8'he6);
    chk({7'h00, CMP_A_IRQ_O}, 8'h01);
    la = 1'b0;
    repeat (6) @(negedge REF_CLK_I);
    rd(8'h9b, 8'hb6);
    wr(8'h9b, 8'h96);
    @(negedge REF_CLK_I);
    chk({7'h00, CMP_A_IRQ_O}, 8'h00);
    wr(8'h9d, 8'h10);
    @(negedge REF_CLK_I);
    chk({7'h00, CMP_A_IRQ_O}, 8'h01);
    $display("edge done");
  endtask
  task t_disable;
    wr(8'h9d, 8'h00);
    wr(8'h9b, 8'h00);
    wr(8'h9a, 8'h8e);
    wr(8'h9a, 8'h8e);
    wr(8'h9e, 8'h25);
    chk({CMP_B_POS_INPUT_SEL_O, CMP_B_NEG_INPUT_SEL_O, 2'h0}, 8'ha8);
    chk({CMP_B_POS_HYST_O, CMP_B_NEG_HYST_O, 4'h0}, 8'he0);
    lb = 1'b1;
    repeat (6) @(negedge REF_CLK_I);
    chk({CMP_A_PIN_O, CMP_B_PIN_O, 6'h00}, 8'h40);
    rd(8'h9a, 8'hee);
    chk({CMP_A_ENABLE_O, CMP_B_ENABLE_O, CMP_B_IRQ_O, 5'h0}, 8'h40);
    wr(8'h9c, 8'h21);
    @(negedge REF_CLK_I);
    chk({CMP_B_IRQ_O, 5'h0, CMP_B_RESPONSE_MODE_O}, 8'h81);
    $display("disable done");
  endtask
  task complete_run;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial forever #50 REF_CLK_I = ~REF_CLK_I;
  always @(posedge REF_CLK_I) begin
    cyc++;
    if (cyc == 1000) begin
      fails++;
      complete_run;
    end
  end
  initial begin
    repeat (5) @(negedge REF_CLK_I);
    SYS_RST_I = 1'b0;
    t_reset;
    t_fields;
    t_edge;
    t_disable;
    complete_run;
  end
endmodule // cmp_regs_bench
